// >>> rtl/tic_params.svh
// Purpose: constants for the timer and external interrupt control register
// Assumes: 8-bit special-function register bus
// Notes: offsets, field positions and reset value
`ifndef TIC_PARAMS_SVH
`define TIC_PARAMS_SVH
`define TIC_ADDR 8'h88
`define TIC_PAGE 8'h00
`define TIC_RESET 8'h00
`define TIC_BIT_T1_OVF 7
`define TIC_BIT_T1_RUN 6
`define TIC_BIT_T0_OVF 5
`define TIC_BIT_T0_RUN 4
`define TIC_BIT_X1_FLAG 3
`define TIC_BIT_X1_TYPE 2
`define TIC_BIT_X0_FLAG 1
`define TIC_BIT_X0_TYPE 0
`endif

// >>> rtl/tic_pkg.sv
// Purpose: types for the timer and external interrupt control register
// Assumes: nothing
// Notes: register bus access travels as one struct
package tic_pkg;
   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic bitWrEn;
      logic [7:0] addr;
      logic [7:0] page;
      logic [2:0] bitSel;
      logic [7:0] wrData;
   } tic_bus_s;
   typedef enum logic [1:0] {
      TIC_LEVEL = 2'b01,
      TIC_EDGE = 2'b10
   } tic_trig_e;
endpackage : tic_pkg

// >>> rtl/tic_ext_detect.sv
// Purpose: synchroniser and edge or level detector for one external interrupt pin
// Assumes: pin is asynchronous to clk
// Notes: polarity inverts an active-low input before detection
`timescale 1ns/100ps
module tic_ext_detect
(
   input wire logic clk,
   input wire logic reset,
   input wire logic pinIn,
   input wire logic polarityHigh,
   input wire logic edgeMode,
   output logic setPulse,
   output logic activeLevel
);
   logic sync1_r;
   logic sync2_r;
   logic prev_r;
   logic sync1_nxt;
   logic sync2_nxt;
   logic prev_nxt;
   logic act;
   logic [1:0] primed_r;
   logic [1:0] primed_nxt;

   always_comb
   begin
      sync1_nxt = pinIn;
      sync2_nxt = sync1_r;
      act = polarityHigh ? sync2_r : ~sync2_r;
      prev_nxt = act;
      // hold detection off until the synchroniser holds real pin samples
      primed_nxt = {primed_r[0], 1'b1};
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r <= 1'b0;
         primed_r <= 2'h0;
      end
      else
      begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
         prev_r <= prev_nxt;
         primed_r <= primed_nxt;
      end
   end

   assign activeLevel = act;
   assign setPulse = primed_r[1] & (edgeMode ? (act & ~prev_r) : act);
endmodule : tic_ext_detect

// >>> rtl/tic_control.sv
// Purpose: timer run/overflow and external interrupt control register
// Assumes: special-function register bus with byte and bit writes
// Notes: hardware set wins over any clear in the same cycle
`timescale 1ns/100ps
`include "tic_params.svh"

// Functional notes
// - timer 1 overflow sets bit 7
// - timer 1 flag cleared by software or vector
// - bit 6 enables timer 1 counting
// - timer 0 overflow sets bit 5
// - timer 0 flag cleared by software or vector
// - bit 4 enables timer 0 counting
// - ext 1 flag bit 3, vector clears edge
// - ext 0 flag bit 1, vector clears edge
// - bit 2 selects ext 1 level or edge
// - bit 0 selects ext 0 level or edge
// - ext 1 polarity from separate config bit
// - ext 0 polarity from separate config bit
// - address 0x88 page 0, bit-addressable, reset zero
module tic_control
(
   input wire logic clk,
   input wire logic reset,
   input tic_pkg::tic_bus_s sfrBus,
   output logic [7:0] rdData,
   output logic rdHit,
   input wire logic timer1Overflow,
   input wire logic timer0Overflow,
   input wire logic vectorTimer1,
   input wire logic vectorTimer0,
   input wire logic vectorExt1,
   input wire logic vectorExt0,
   input wire logic ext_irq1_input,
   input wire logic ext_irq0_input,
   input wire logic ext_irq1_polarity,
   input wire logic ext_irq0_polarity,
   output logic timer1_run,
   output logic timer0_run,
   output logic [7:0] timer_irq_control
);
   logic [7:0] ctrl_r;
   logic [7:0] ctrl_nxt;
   logic [7:0] rdData_r;
   logic [7:0] rdData_nxt;
   logic rdHit_r;
   logic rdHit_nxt;
   logic hit;
   logic [7:0] wrMask;
   logic [7:0] setMask;
   logic [7:0] clrMask;
   logic x1Set;
   logic x0Set;
   logic x1Active;
   logic x0Active;
   tic_pkg::tic_trig_e x1Mode;
   tic_pkg::tic_trig_e x0Mode;

   // ----------------------------------------
   // external pin detectors
   // ----------------------------------------
   assign x1Mode = ctrl_r[`TIC_BIT_X1_TYPE] ? tic_pkg::TIC_EDGE : tic_pkg::TIC_LEVEL;
   assign x0Mode = ctrl_r[`TIC_BIT_X0_TYPE] ? tic_pkg::TIC_EDGE : tic_pkg::TIC_LEVEL;

   tic_ext_detect u_ext1
   (
      .clk(clk),
      .reset(reset),
      .pinIn(ext_irq1_input),
      .polarityHigh(ext_irq1_polarity),
      .edgeMode(x1Mode == tic_pkg::TIC_EDGE),
      .setPulse(x1Set),
      .activeLevel(x1Active)
   );

   tic_ext_detect u_ext0
   (
      .clk(clk),
      .reset(reset),
      .pinIn(ext_irq0_input),
      .polarityHigh(ext_irq0_polarity),
      .edgeMode(x0Mode == tic_pkg::TIC_EDGE),
      .setPulse(x0Set),
      .activeLevel(x0Active)
   );

   // ----------------------------------------
   // register update
   // ----------------------------------------
   // address decode
   assign hit = (sfrBus.addr == `TIC_ADDR) && (sfrBus.page == `TIC_PAGE);

   always_comb
   begin
      wrMask = 8'h00;
      if (hit && sfrBus.wrEn)
      begin
         if (sfrBus.bitWrEn)
            wrMask[sfrBus.bitSel] = 1'b1;
         else
            wrMask = 8'hff;
      end
      setMask = 8'h00;
      clrMask = 8'h00;
      setMask[`TIC_BIT_T1_OVF] = timer1Overflow;
      setMask[`TIC_BIT_T0_OVF] = timer0Overflow;
      setMask[`TIC_BIT_X1_FLAG] = x1Set;
      setMask[`TIC_BIT_X0_FLAG] = x0Set;
      clrMask[`TIC_BIT_T1_OVF] = vectorTimer1;
      clrMask[`TIC_BIT_T0_OVF] = vectorTimer0;
      clrMask[`TIC_BIT_X1_FLAG] = vectorExt1 && (x1Mode == tic_pkg::TIC_EDGE);
      clrMask[`TIC_BIT_X0_FLAG] = vectorExt0 && (x0Mode == tic_pkg::TIC_EDGE);
      ctrl_nxt = (ctrl_r & ~wrMask) | (sfrBus.wrData & wrMask);
      ctrl_nxt = (ctrl_nxt & ~clrMask) | setMask;
      rdHit_nxt = hit && sfrBus.rdEn;
      rdData_nxt = rdHit_nxt ? ctrl_r : 8'h00;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         ctrl_r <= `TIC_RESET;
         rdData_r <= 8'h00;
         rdHit_r <= 1'b0;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
         rdData_r <= rdData_nxt;
         rdHit_r <= rdHit_nxt;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // timer 1 enable
   assign timer1_run = ctrl_r[`TIC_BIT_T1_RUN];
   assign timer0_run = ctrl_r[`TIC_BIT_T0_RUN];
   assign timer_irq_control = ctrl_r;
   assign rdData = rdData_r;
   assign rdHit = rdHit_r;
endmodule : tic_control

// >>> sim/tic_timer.sv
// Purpose: timer counter model on the far side of the run bits
// Assumes: one overflow every four counts
// Notes: overflow is a one-cycle pulse
`timescale 1ns/100ps
module tic_timer
(
   input wire logic clk,
   input wire logic reset,
   input wire logic run,
   output logic ovf
);
   logic [1:0] cnt_r;
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         cnt_r <= 2'h0;
      else
         cnt_r <= cnt_r + 2'(run);
   end
   assign ovf = run && cnt_r == 2'h3;
endmodule : tic_timer

// >>> sim/tic_control_sva.sv
// Purpose: property checks on tic_control
// Assumes: one clock domain
// Notes: bound at file end
`timescale 1ns/100ps
module tic_sva
(
   input wire logic clk,
   input wire logic reset,
   input tic_pkg::tic_bus_s sfrBus,
   input wire logic [7:0] rdData,
   input wire logic rdHit,
   input wire logic timer1Overflow,
   input wire logic vectorTimer1,
   input wire logic [7:0] timer_irq_control
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   wire hit = sfrBus.addr == 8'h88 && sfrBus.page == 8'h00;
   wire wr = sfrBus.wrEn && hit;
   wire idle1 = !timer1Overflow && !vectorTimer1 && !wr;
   wire [7:0] q = timer_irq_control;
   a_t1_set: assert property (timer1Overflow |=> q[7])
      else $error("t1 flag not set");
   a_t1_clr: assert property (vectorTimer1 && !timer1Overflow |=> !q[7])
      else $error("t1 flag not cleared");
   a_t1_hold: assert property (idle1 |=> $stable(q[7]))
      else $error("t1 flag moved");
   a_run_wr: assert property (wr && !sfrBus.bitWrEn |=> q[6] == $past(sfrBus.wrData[6]))
      else $error("run bit wrong");
   a_bit_wr: assert property (wr && sfrBus.bitWrEn && !sfrBus.bitSel[0]
      |=> q[$past(sfrBus.bitSel)] == $past(sfrBus.wrData[sfrBus.bitSel]))
      else $error("bit write wrong");
   a_rd_data: assert property (sfrBus.rdEn && hit |=> rdHit && rdData == $past(q))
      else $error("read wrong");
   a_rd_miss: assert property (sfrBus.rdEn && !hit |=> !rdHit)
      else $error("miss answered");
   a_rst_zero: assert property ($fell(reset) |-> q == 8'h00)
      else $error("reset value");
   c_read: cover property (rdHit);
   c_ovf: cover property (timer1Overflow);
   c_vec: cover property (vectorTimer1);
endmodule : tic_sva
bind tic_control tic_sva sva (.clk, .reset, .sfrBus, .rdData, .rdHit, .timer1Overflow,
   .vectorTimer1, .timer_irq_control);

// >>> sim/test_timer_extirq_control_reg.sv
// Purpose: bench for tic_control
// Assumes: timers modelled by tic_timer
// Notes: inputs change at the falling edge
`timescale 1ns/100ps
module test_timer_extirq_control_reg;
   logic clk = 0, reset = 1, rdHit, t1, t0, r1, r0;
   logic v1 = 0, v0 = 0, x1 = 0, x0 = 0, p1 = 1, p0 = 0;
   logic [7:0] rdData, q;
   tic_pkg::tic_bus_s b = '0;
   int failures = 0, checked = 0;
   always #4 clk = ~clk;
   tic_control uut (.clk, .reset, .sfrBus(b), .rdData, .rdHit, .timer1Overflow(t1),
      .timer0Overflow(t0), .vectorTimer1(v1), .vectorTimer0(v0), .vectorExt1(x1),
      .vectorExt0(x0), .ext_irq1_input(p1), .ext_irq0_input(p0), .ext_irq1_polarity(1'b0),
      .ext_irq0_polarity(1'b1), .timer1_run(r1), .timer0_run(r0), .timer_irq_control(q));
   tic_timer m1 (.clk, .reset, .run(r1), .ovf(t1));
   tic_timer m0 (.clk, .reset, .run(r0), .ovf(t0));
   task automatic chk(string n, logic [7:0] s, logic [7:0] e);
      checked++;
      if (s !== e)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic acc(logic w, logic [7:0] a, logic bw, logic [2:0] s, logic [7:0] d);
      @(negedge clk);
      b = '{w, !w, bw, a, 8'h00, s, d};
      @(negedge clk);
      b = '0;
   endtask : acc
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1;
      @(negedge clk);
      s = 0;
   endtask : pulse
   task automatic finish_test;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test
   task automatic t_regs;
      chk("reset", q, 8'h00);
      acc(1, 8'h88, 0, 0, 8'h0c);
      acc(0, 8'h88, 0, 0, 8'h00);
      chk("read", rdData, 8'h0c);
      acc(0, 8'h89, 0, 0, 8'h00);
      chk("miss", 8'(rdHit), 8'h00);
      acc(1, 8'h88, 1, 3, 8'h00);
      chk("bitclr", q, 8'h04);
      $display("regs done");
   endtask : t_regs
   task automatic t_timers;
      acc(1, 8'h88, 0, 0, 8'h50);
      repeat (6) @(negedge clk);
      chk("ovf", q, 8'hf0);
      acc(1, 8'h88, 0, 0, 8'ha4);
      pulse(v1);
      chk("vec1", q, 8'h24);
      pulse(v0);
      chk("vec0", q, 8'h04);
      $display("timers done");
   endtask : t_timers
   task automatic t_ext;
      p0 = 1;
      repeat (4) @(negedge clk);
      chk("lvl0", q, 8'h06);
      acc(1, 8'h88, 1, 1, 8'h00);
      chk("relvl0", q, 8'h06);
      p0 = 0;
      repeat (3) @(negedge clk);
      acc(1, 8'h88, 1, 0, 8'h01);
      acc(1, 8'h88, 1, 1, 8'h00);
      chk("clr0", q, 8'h05);
      p0 = 1;
      p1 = 0;
      repeat (4) @(negedge clk);
      chk("edge", q, 8'h0f);
      pulse(x1);
      pulse(x0);
      chk("vecx", q, 8'h05);
      $display("ext done");
   endtask : t_ext
   initial
   begin
      #20000;
      failures++;
      finish_test();
   end
   initial
   begin
      repeat (10) @(negedge clk);
      reset = 0;
      t_regs();
      t_timers();
      t_ext();
      finish_test();
   end
endmodule : test_timer_extirq_control_reg
